/* File: core/ccd_top.sv */
// channel clock dividers: register file on apb, two single-stage and two cascaded dividers
//
// Operation
// - duty fix is on after reset; each channel's duty_fix_disable bit turns it off
// - 50% needs low equal high for even, low equal high plus one for odd
// - uncorrected output is high for high_period+1 of high+low+2 input cycles
// - bypassed divider after vco divider: 50% even, 1 of 3, 2 of 5
// - odd vco divide with correction gives (1+X)/3 or (2+X)/5, even 50%
// - corrected odd channel ratio after odd vco divide gives the stated mixed duty
// - without vco divider: bypass passes input duty, corrected even ratios give 50%
// - direct route gives the source waveform unchanged on the output pair
// - coarse offset delays the output rising edge by counted input rising edges
// - delay code is begin_high_flag times 16 plus the four-bit edge_delay_count
// - code up to 15 delays code cycles, else code-16+low_period+1 cycles
// - new offsets take effect only at the next sync event
// - divider 1 offset and count fields sit as for divider 0
// - dividers 2 and 3 are two cascaded 2-to-32 stages, product up to 1024
// - cascaded ratio: both bypassed 1, second bypassed first ratio, else product
// - each stage holds low and high counts as count minus one
// - divider 2 stage bypasses at bits 4 and 5, one shared duty_fix_disable
// - divider 3 stage bypasses at bits 4 and 5, one shared duty_fix_disable
// - in single-ended mode the B output stays off until enabled
// - dividers 0 and 1 divide by low+high+2; bypass gives divide by one
// - divider 0 bypass at phase register bit 7 powers the divider down; here its stage is only held stopped, with no power-down
// - vco divider divides by 2 to 6 from a three-bit selector
`timescale 1ns/1ps
module ccd_top import ccd_pkg::*; (
  input  wire logic     clock,
  input  wire logic     srst,
  input  ccd_apb_req_s  apbReq,
  output ccd_apb_rsp_s  apbRsp,
  output logic [NOUT-1:0] outClk
);
  typedef struct packed {
    logic [NSLOT-1:0][7:0] regs;
    logic                  pready;
    logic                  pslverr;
    logic [DATA_W-1:0]     prdata;
    logic                  syncPend;
    logic                  rawLvl;
    logic [NOUT-1:0]       outClk;
  } ccd_top_st_s;

  ccd_top_st_s st_r;
  ccd_top_st_s st_nxt;

  // address decode, used for both the read and the write path
  function automatic logic [4:0] slotOf(input logic [ADDR_W-1:0] addr);
    logic [4:0] slot;
    slot = SLOT_UNMAPPED;
    if (addr[1:0] == 2'h0) begin
      for (int k = 0; k < NSLOT; k++) begin
        if (addr[ADDR_W-1:2] == 10'(SLOT_IDX[k])) begin
          slot = 5'(k);
        end
      end
      if (addr[ADDR_W-1:2] == 10'(IDX_SYNC_CONTROL)) begin
        slot = SLOT_SYNC;
      end
      if (addr[ADDR_W-1:2] == 10'(IDX_STATUS)) begin
        slot = SLOT_STATUS;
      end
    end
    return slot;
  endfunction

  // division of one stage from its stored low and high fields
  function automatic logic [5:0] stageRatio(input logic [7:0] counts);
    return 6'(6'(counts[LOW_MSB:LOW_LSB]) + 6'(counts[HIGH_MSB:HIGH_LSB]) + 6'h02);
  endfunction

  // start delay in input cycles from the five-bit delay code
  function automatic logic [5:0] phaseDelay(input logic [7:0] phase, input logic [7:0] counts);
    logic [5:0] dly;
    dly = 6'(phase[EDGE_DELAY_MSB:EDGE_DELAY_LSB]);
    if (phase[BEGIN_HIGH_BIT]) begin
      dly = 6'(dly + 6'(counts[LOW_MSB:LOW_LSB]) + 6'h01);
    end
    return dly;
  endfunction

  // source and vco divider
  logic       vcoUsed;
  logic       vTick;
  logic       vLvl;
  logic [2:0] clkPerIn;
  logic       syncPulse;

  assign vcoUsed   = (st_r.regs[SLOT_SRC_SEL][SRC_SEL_MSB:0] != SRC_CLK_NO_VCODIV);
  assign syncPulse = st_r.syncPend;

  ccd_vco_div u_vco (
    .clock    (clock),
    .srst     (srst),
    .ratioSel (st_r.regs[SLOT_VCO_SEL][VCO_SEL_MSB:0]),
    .used     (vcoUsed),
    .tick     (vTick),
    .lvl      (vLvl),
    .clkPerIn (clkPerIn)
  );

  // single-stage dividers 0 and 1
  logic [1:0] sdLvl;
  logic [1:0] sdDirect;

  for (genvar i = 0; i < 2; i++) begin : g_single
    ccd_stage_cfg_s cfg;
    logic           bypass;
    logic           stLvl;
    logic [7:0]     counts;
    logic [7:0]     phase;

    assign counts         = st_r.regs[SLOT_SD_COUNTS[i]];
    assign phase          = st_r.regs[SLOT_SD_PHASE[i]];
    assign bypass         = phase[SD_BYPASS_BIT];
    assign cfg.lowCnt     = counts[LOW_MSB:LOW_LSB];
    assign cfg.highCnt    = counts[HIGH_MSB:HIGH_LSB];
    assign cfg.dccOn      = ~st_r.regs[SLOT_SD_CTRL[i]][DUTY_FIX_DIS_BIT];
    assign cfg.halfClk    = 8'(clkPerIn >> 1);
    assign cfg.startDelay = phaseDelay(phase, counts);
    assign sdDirect[i]    = st_r.regs[SLOT_SD_CTRL[i]][DIRECT_OUT_BIT];

    // a bypassed divider is held stopped, standing in for power-down
    ccd_stage u_stage (
      .clock  (clock),
      .srst   (srst),
      .tickIn (vTick),
      .start  (syncPulse | bypass),
      .cfg    (cfg),
      .lvl    (stLvl),
      .rise   ()
    );

    assign sdLvl[i] = bypass ? vLvl : stLvl;
  end

  // cascaded dividers 2 and 3
  logic [1:0] cdLvl;

  for (genvar j = 0; j < 2; j++) begin : g_cascade
    ccd_stage_cfg_s cfg1;
    ccd_stage_cfg_s cfg2;
    logic           byp1;
    logic           byp2;
    logic           dccOn;
    logic           lvl1;
    logic           lvl2;
    logic           rise1;
    logic [5:0]     ratio1;
    logic [8:0]     period1;
    logic [7:0]     c1;
    logic [7:0]     c2;

    assign c1    = st_r.regs[SLOT_CD_STAGE1[j]];
    assign c2    = st_r.regs[SLOT_CD_STAGE2[j]];
    assign byp1  = st_r.regs[SLOT_CD_BYPASS[j]][STAGE1_BYPASS_BIT];
    assign byp2  = st_r.regs[SLOT_CD_BYPASS[j]][STAGE2_BYPASS_BIT];
    assign dccOn = ~st_r.regs[SLOT_CD_DUTY[j]][DUTY_FIX_DIS_BIT];

    // input period of the second stage, in clocks, sets its half-cycle
    assign ratio1  = byp1 ? 6'h01 : stageRatio(c1);
    assign period1 = 9'(9'(ratio1) * 9'(clkPerIn));

    assign cfg1.lowCnt     = c1[LOW_MSB:LOW_LSB];
    assign cfg1.highCnt    = c1[HIGH_MSB:HIGH_LSB];
    assign cfg1.dccOn      = dccOn;
    assign cfg1.halfClk    = 8'(clkPerIn >> 1);
    assign cfg1.startDelay = 6'h00;
    assign cfg2.lowCnt     = c2[LOW_MSB:LOW_LSB];
    assign cfg2.highCnt    = c2[HIGH_MSB:HIGH_LSB];
    assign cfg2.dccOn      = dccOn;
    assign cfg2.halfClk    = 8'(period1 >> 1);
    assign cfg2.startDelay = 6'h00;

    ccd_stage u_first (
      .clock  (clock),
      .srst   (srst),
      .tickIn (vTick),
      .start  (syncPulse | byp1),
      .cfg    (cfg1),
      .lvl    (lvl1),
      .rise   (rise1)
    );

    // second stage counts rising edges of the first stage's output
    ccd_stage u_second (
      .clock  (clock),
      .srst   (srst),
      .tickIn (byp1 ? vTick : rise1),
      .start  (syncPulse | byp2),
      .cfg    (cfg2),
      .lvl    (lvl2),
      .rise   ()
    );

    always_comb begin
      if (!byp2) begin
        cdLvl[j] = lvl2;
      end else if (!byp1) begin
        cdLvl[j] = lvl1;
      end else begin
        cdLvl[j] = vLvl;
      end
    end
  end

  // bus slave, sync request and output registers
  logic [4:0] slot;
  logic       access;
  logic       finish;

  assign slot   = slotOf(apbReq.paddr);
  assign access = apbReq.psel && apbReq.penable;
  assign finish = access && st_r.pready;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.pready   = 1'b0;
    st_nxt.syncPend = 1'b0;
    st_nxt.rawLvl   = ~st_r.rawLvl;
    if (access && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = (slot == SLOT_UNMAPPED);
      st_nxt.prdata  = '0;
      if (!apbReq.pwrite) begin
        if (slot < 5'(NSLOT)) begin
          st_nxt.prdata = 32'(st_r.regs[slot]);
        end else if (slot == SLOT_STATUS) begin
          st_nxt.prdata = 32'({vcoUsed, st_r.outClk});
        end
      end
    end
    if (finish && apbReq.pwrite && !st_r.pslverr && apbReq.pstrb[0]) begin
      if (slot < 5'(NSLOT)) begin
        st_nxt.regs[slot] = apbReq.pwdata[7:0];
      end else if (slot == SLOT_SYNC) begin
        st_nxt.syncPend = apbReq.pwdata[SYNC_BIT];
      end
    end
    // direct route bypasses the divider: source waveform passes unchanged
    st_nxt.outClk[0] = sdDirect[0] ? st_r.rawLvl : sdLvl[0];
    st_nxt.outClk[1] = sdDirect[1] ? st_r.rawLvl : sdLvl[1];
    for (int k = 0; k < 2; k++) begin
      st_nxt.outClk[2 + 2 * k] = cdLvl[k];
      if (st_r.regs[SLOT_OUT_MODE][CMOS_MODE_BIT[k]]) begin
        st_nxt.outClk[3 + 2 * k] = st_r.regs[SLOT_OUT_MODE][B_ENABLE_BIT[k]] & cdLvl[k];
      end else begin
        st_nxt.outClk[3 + 2 * k] = ~cdLvl[k];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r          <= '0;
      st_r.regs     <= {NSLOT{REG_RESET}};
      st_r.syncPend <= SYNC_PEND_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign apbRsp.pready  = st_r.pready;
  assign apbRsp.pslverr = st_r.pslverr;
  assign apbRsp.prdata  = st_r.prdata;
  assign outClk         = st_r.outClk;
endmodule

/* File: core/ccd_pkg.sv */
// package: register map, field layout, reset values and carrier types of the channel clock dividers
package ccd_pkg;

  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned IDX_W    = 9;

  // register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DIV0_CYCLE_COUNTS  = 9'h190;
  localparam logic [IDX_W-1:0] IDX_DIV0_PHASE_BYPASS  = 9'h191;
  localparam logic [IDX_W-1:0] IDX_DIV0_OUT_CONTROL   = 9'h192;
  localparam logic [IDX_W-1:0] IDX_DIV1_CYCLE_COUNTS  = 9'h196;
  localparam logic [IDX_W-1:0] IDX_DIV1_PHASE_BYPASS  = 9'h197;
  localparam logic [IDX_W-1:0] IDX_DIV1_OUT_CONTROL   = 9'h198;
  localparam logic [IDX_W-1:0] IDX_DIV2_STAGE1_COUNTS = 9'h199;
  localparam logic [IDX_W-1:0] IDX_DIV2_STAGE2_COUNTS = 9'h19b;
  localparam logic [IDX_W-1:0] IDX_DIV2_STAGE_BYPASS  = 9'h19c;
  localparam logic [IDX_W-1:0] IDX_DIV2_DUTY_CONTROL  = 9'h19d;
  localparam logic [IDX_W-1:0] IDX_DIV3_STAGE1_COUNTS = 9'h19e;
  localparam logic [IDX_W-1:0] IDX_DIV3_STAGE2_COUNTS = 9'h1a0;
  localparam logic [IDX_W-1:0] IDX_DIV3_STAGE_BYPASS  = 9'h1a1;
  localparam logic [IDX_W-1:0] IDX_DIV3_DUTY_CONTROL  = 9'h1a2;
  localparam logic [IDX_W-1:0] IDX_VCO_DIV_SELECT     = 9'h1e0;
  localparam logic [IDX_W-1:0] IDX_SOURCE_SELECT      = 9'h1e1;
  localparam logic [IDX_W-1:0] IDX_SYNC_CONTROL       = 9'h1f0;
  localparam logic [IDX_W-1:0] IDX_OUTPUT_MODE        = 9'h1f1;
  localparam logic [IDX_W-1:0] IDX_STATUS             = 9'h1f2;

  // storage slots
  localparam int unsigned NSLOT = 17;
  localparam logic [4:0] SLOT_SYNC     = 5'h11;
  localparam logic [4:0] SLOT_STATUS   = 5'h12;
  localparam logic [4:0] SLOT_UNMAPPED = 5'h1f;
  localparam logic [IDX_W-1:0] SLOT_IDX [NSLOT] = '{
    IDX_DIV0_CYCLE_COUNTS, IDX_DIV0_PHASE_BYPASS, IDX_DIV0_OUT_CONTROL,
    IDX_DIV1_CYCLE_COUNTS, IDX_DIV1_PHASE_BYPASS, IDX_DIV1_OUT_CONTROL,
    IDX_DIV2_STAGE1_COUNTS, IDX_DIV2_STAGE2_COUNTS, IDX_DIV2_STAGE_BYPASS, IDX_DIV2_DUTY_CONTROL,
    IDX_DIV3_STAGE1_COUNTS, IDX_DIV3_STAGE2_COUNTS, IDX_DIV3_STAGE_BYPASS, IDX_DIV3_DUTY_CONTROL,
    IDX_VCO_DIV_SELECT, IDX_SOURCE_SELECT, IDX_OUTPUT_MODE};
  // per divider pair (0,1) and per cascaded divider (2,3)
  localparam int unsigned SLOT_SD_COUNTS [2] = '{0, 3};
  localparam int unsigned SLOT_SD_PHASE  [2] = '{1, 4};
  localparam int unsigned SLOT_SD_CTRL   [2] = '{2, 5};
  localparam int unsigned SLOT_CD_STAGE1 [2] = '{6, 10};
  localparam int unsigned SLOT_CD_STAGE2 [2] = '{7, 11};
  localparam int unsigned SLOT_CD_BYPASS [2] = '{8, 12};
  localparam int unsigned SLOT_CD_DUTY   [2] = '{9, 13};
  localparam int unsigned SLOT_VCO_SEL   = 14;
  localparam int unsigned SLOT_SRC_SEL   = 15;
  localparam int unsigned SLOT_OUT_MODE  = 16;

  // field positions
  localparam int unsigned LOW_MSB            = 7;
  localparam int unsigned LOW_LSB            = 4;
  localparam int unsigned HIGH_MSB           = 3;
  localparam int unsigned HIGH_LSB           = 0;
  localparam int unsigned SD_BYPASS_BIT      = 7;
  localparam int unsigned BEGIN_HIGH_BIT     = 4;
  localparam int unsigned EDGE_DELAY_MSB     = 3;
  localparam int unsigned EDGE_DELAY_LSB     = 0;
  localparam int unsigned DUTY_FIX_DIS_BIT   = 0;
  localparam int unsigned DIRECT_OUT_BIT     = 1;
  localparam int unsigned STAGE1_BYPASS_BIT  = 4;
  localparam int unsigned STAGE2_BYPASS_BIT  = 5;
  localparam int unsigned VCO_SEL_MSB        = 2;
  localparam int unsigned SRC_SEL_MSB        = 1;
  localparam int unsigned SYNC_BIT           = 0;
  localparam int unsigned CMOS_MODE_BIT [2]  = '{0, 1};
  localparam int unsigned B_ENABLE_BIT  [2]  = '{2, 3};

  // values
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam logic       SYNC_PEND_RESET  = 1'b1;
  localparam logic [1:0] SRC_CLK_NO_VCODIV = 2'h1;
  localparam logic [2:0] VCO_SEL_MAX      = 3'h4;
  localparam logic [2:0] VCO_RATIO_MIN    = 3'h2;
  localparam int unsigned NOUT            = 6;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
  } ccd_apb_req_s;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } ccd_apb_rsp_s;

  typedef struct packed {
    logic [3:0] lowCnt;
    logic [3:0] highCnt;
    logic       dccOn;
    logic [7:0] halfClk;
    logic [5:0] startDelay;
  } ccd_stage_cfg_s;

endpackage

/* File: core/ccd_vco_div.sv */
// divider ahead of the channel dividers: edge tick and divided level
`timescale 1ns/1ps
module ccd_vco_div import ccd_pkg::*; (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [2:0] ratioSel,
  input  wire logic       used,
  output logic            tick,
  output logic            lvl,
  output logic [2:0]      clkPerIn
);
  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
    logic       lvl;
  } ccd_vco_st_s;

  ccd_vco_st_s st_r;
  ccd_vco_st_s st_nxt;
  logic [2:0]  ratio;

  // selector codes past the last ratio fold onto the smallest one
  assign ratio    = (ratioSel > VCO_SEL_MAX) ? VCO_RATIO_MIN : 3'(ratioSel + VCO_RATIO_MIN);
  assign tick     = st_r.tick;
  assign lvl      = st_r.lvl;
  assign clkPerIn = used ? ratio : 3'h1;

  always_comb begin
    st_nxt = st_r;
    if (!used) begin
      st_nxt.cnt  = 3'h0;
      st_nxt.tick = 1'b1;
      st_nxt.lvl  = ~st_r.lvl;
    end else begin
      st_nxt.cnt  = (st_r.cnt >= 3'(ratio - 3'h1)) ? 3'h0 : 3'(st_r.cnt + 3'h1);
      st_nxt.tick = (st_nxt.cnt == 3'h0);
      // odd ratios run high for the floor half: 1 of 3, 2 of 5
      st_nxt.lvl  = (st_nxt.cnt < (ratio >> 1));
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* File: core/ccd_stage.sv */
// one divider stage: high and low counters, start delay, half-cycle late fall
`timescale 1ns/1ps
module ccd_stage import ccd_pkg::*; (
  input  wire logic     clock,
  input  wire logic     srst,
  input  wire logic     tickIn,
  input  wire logic     start,
  input  ccd_stage_cfg_s cfg,
  output logic          lvl,
  output logic          rise
);
  typedef enum logic [1:0] {ST_DELAY, ST_HIGH, ST_LOW} ccd_stage_e;
  typedef struct packed {
    ccd_stage_e state;
    logic [5:0] cnt;
    logic [7:0] hold;
    logic       lvl;
    logic       rise;
  } ccd_stage_st_s;

  ccd_stage_st_s st_r;
  ccd_stage_st_s st_nxt;
  logic          oddFix;

  assign oddFix = cfg.dccOn && (cfg.lowCnt[0] ^ cfg.highCnt[0]) && (cfg.halfClk != 8'h00);
  assign lvl    = st_r.lvl;
  assign rise   = st_r.rise;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.rise = 1'b0;
    if (st_r.hold != 8'h00) begin
      st_nxt.hold = 8'(st_r.hold - 8'h01);
      if (st_r.hold == 8'h01) begin
        st_nxt.lvl = 1'b0;
      end
    end
    if (start) begin
      st_nxt.state = ST_DELAY;
      st_nxt.cnt   = cfg.startDelay;
      st_nxt.hold  = 8'h00;
      st_nxt.lvl   = 1'b0;
    end else if (tickIn) begin
      case (st_r.state)
        ST_DELAY, ST_LOW: begin
          if (st_r.cnt == 6'h00) begin
            st_nxt.state = ST_HIGH;
            st_nxt.cnt   = {2'h0, cfg.highCnt};
            st_nxt.hold  = 8'h00;
            st_nxt.lvl   = 1'b1;
            st_nxt.rise  = 1'b1;
          end else begin
            st_nxt.cnt = 6'(st_r.cnt - 6'h01);
          end
        end
        ST_HIGH: begin
          if (st_r.cnt == 6'h00) begin
            st_nxt.state = ST_LOW;
            st_nxt.cnt   = {2'h0, cfg.lowCnt};
            if (oddFix) begin
              st_nxt.hold = cfg.halfClk;
            end else begin
              st_nxt.lvl = 1'b0;
            end
          end else begin
            st_nxt.cnt = 6'(st_r.cnt - 6'h01);
          end
        end
        default: begin
          st_nxt.state = ST_DELAY;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* File: sim/ccd_top_chk.sv */
// assertion checker of the channel clock dividers, bound to ccd_top
`timescale 1ns/1ps
module ccd_top_chk import ccd_pkg::*; (
  input wire logic            clock,
  input wire logic            srst,
  input ccd_apb_req_s         apbReq,
  input ccd_apb_rsp_s         apbRsp,
  input wire logic [NOUT-1:0] outClk
);
  logic [3:0] modeR;
  logic [6:0] hiRun;
  logic       acc;
  logic       modeWr;
  assign acc = apbReq.psel && apbReq.penable;
  assign modeWr = acc && apbRsp.pready && apbReq.pwrite && apbReq.pstrb[0] && !apbRsp.pslverr
                  && apbReq.paddr == {1'b0, IDX_OUTPUT_MODE, 2'b00};
  // mirror of the output mode register, taken from completed writes
  always_ff @(posedge clock) begin
    if (srst) begin
      modeR <= 4'h0;
    end else if (modeWr) begin
      modeR <= apbReq.pwdata[3:0];
    end
  end
  // length of the present high run of the divider 0 output
  always_ff @(posedge clock) begin
    if (srst || !outClk[0]) begin
      hiRun <= 7'h00;
    end else if (hiRun != 7'h7f) begin
      hiRun <= hiRun + 7'h01;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  property p_rdy_pulse;
    apbRsp.pready |=> !apbRsp.pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready stood longer than one cycle");
  property p_rdy_wait;
    acc && !apbRsp.pready |=> apbRsp.pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready not one cycle after access start");
  property p_rdy_access;
    apbRsp.pready |-> acc;
  endproperty
  a_rdy_access: assert property (p_rdy_access) else $error("ready outside an access phase");
  property p_err_align;
    apbRsp.pready && apbReq.paddr[1:0] != 2'b00 |-> apbRsp.pslverr;
  endproperty
  a_err_align: assert property (p_err_align) else $error("misaligned access not refused");
  property p_upper_zero;
    apbRsp.pready |-> apbRsp.prdata[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits not zero");
  property p_err_nodata;
    apbRsp.pready && apbRsp.pslverr |-> apbRsp.prdata == 32'h0000_0000;
  endproperty
  a_err_nodata: assert property (p_err_nodata) else $error("refused access returned data");
  property p_reset_quiet;
    $past(srst) |-> outClk == 6'h00 && !apbRsp.pready;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active right after reset");
  property p_b_off;
    modeR[0] && !modeR[2] && $past(modeR[0]) && !$past(modeR[2]) |-> !outClk[3];
  endproperty
  a_b_off: assert property (p_b_off) else $error("single-ended B output on while disabled");
  property p_hi_bound;
    hiRun <= 7'h63;
  endproperty
  a_hi_bound: assert property (p_hi_bound) else $error("divider 0 high run too long");
endmodule

bind ccd_top ccd_top_chk chk_u (
  .clock  (clock),
  .srst   (srst),
  .apbReq (apbReq),
  .apbRsp (apbRsp),
  .outClk (outClk)
);

/* File: sim/tb_top.sv */
// self-checking testbench of the channel clock dividers
`timescale 1ns/1ps
module tb_top import ccd_pkg::*; ;
  typedef struct packed {
    logic [8:0]  idx;
    logic [7:0]  wd;
    logic [3:0]  pin;
    logic [10:0] hi;
    logic [10:0] per;
  } ccd_row_s;
  localparam ccd_row_s ROWS [18] = '{
    '{IDX_VCO_DIV_SELECT, 8'h00, 4'h0, 11'h002, 11'h004},
    '{IDX_DIV0_OUT_CONTROL, 8'h01, 4'h0, 11'h002, 11'h004},
    '{IDX_DIV0_PHASE_BYPASS, 8'h80, 4'h0, 11'h001, 11'h002},
    '{IDX_VCO_DIV_SELECT, 8'h01, 4'h0, 11'h001, 11'h003},
    '{IDX_VCO_DIV_SELECT, 8'h03, 4'h0, 11'h002, 11'h005},
    '{IDX_SOURCE_SELECT, 8'h01, 4'h0, 11'h001, 11'h002},
    '{IDX_DIV0_PHASE_BYPASS, 8'h00, 4'h0, 11'h001, 11'h002},
    '{IDX_DIV0_CYCLE_COUNTS, 8'h41, 4'h0, 11'h002, 11'h007},
    '{IDX_DIV0_CYCLE_COUNTS, 8'h22, 4'h0, 11'h003, 11'h006},
    '{IDX_DIV0_OUT_CONTROL, 8'h00, 4'h0, 11'h003, 11'h006},
    '{IDX_DIV0_CYCLE_COUNTS, 8'hff, 4'h0, 11'h010, 11'h020},
    '{IDX_DIV0_OUT_CONTROL, 8'h02, 4'h0, 11'h001, 11'h002},
    '{IDX_DIV2_STAGE1_COUNTS, 8'h11, 4'h2, 11'h004, 11'h008},
    '{IDX_DIV2_STAGE_BYPASS, 8'h20, 4'h2, 11'h002, 11'h004},
    '{IDX_DIV2_STAGE_BYPASS, 8'h30, 4'h2, 11'h001, 11'h002},
    '{IDX_DIV3_STAGE1_COUNTS, 8'hff, 4'h4, 11'h020, 11'h040},
    '{IDX_DIV3_STAGE2_COUNTS, 8'hff, 4'h4, 11'h200, 11'h400},
    '{IDX_DIV3_STAGE_BYPASS, 8'h20, 4'h5, 11'h010, 11'h020}};
  logic            clock;
  logic            srst;
  ccd_apb_req_s    apbReq;
  ccd_apb_rsp_s    apbRsp;
  logic [NOUT-1:0] outClk;
  logic [NOUT-1:0] cur;
  logic [NOUT-1:0] prv;
  logic [31:0]     rd;
  logic            err;
  int              errors;
  int              comparisons;
  int              n;
  int              hi;
  int              per;
  int              gap;

  ccd_top dut_u (
    .clock  (clock),
    .srst   (srst),
    .apbReq (apbReq),
    .apbRsp (apbRsp),
    .outClk (outClk)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    comparisons++;
    if (got !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic giveUp();
    errors++;
    $display("MISMATCH wait expected completion seen timeout");
    tally_and_finish();
  endtask
  task automatic step();
    @(posedge clock);
    #1;
    prv = cur;
    cur = outClk;
    n++;
  endtask
  function automatic logic risen(input int b);
    return cur[b] && !prv[b];
  endfunction
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge clock);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: {24'h00_0000, wd}, pstrb: 4'hf};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    // look at the answer once it has settled after the edge that launched it
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (apbRsp.pready !== 1'b1 && k < 20);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    // the edge at which pready is sampled high closes the transfer
    @(posedge clock);
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (k >= 20) giveUp();
  endtask
  function automatic logic [11:0] ad(input logic [8:0] idx);
    return {1'b0, idx, 2'b00};
  endfunction
  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    apb(1'b1, ad(idx), d);
  endtask
  task automatic rdc(input logic [8:0] idx, input logic [7:0] e);
    apb(1'b0, ad(idx), 8'h00);
    chk("read", {24'h00_0000, e}, rd);
    chk("error", 32'h0000_0000, {31'h0, err});
  endtask
  // high and period of the last of three whole periods
  task automatic meas(input int b);
    n = 0;
    repeat (3) begin
      while (!risen(b) && n < 8000) step();
      hi = 0;
      while (cur[b] && n < 8000) begin
        hi++;
        step();
      end
      per = hi;
      while (!cur[b] && n < 8000) begin
        per++;
        step();
      end
    end
    if (n >= 8000) giveUp();
  endtask
  task automatic phaseStep(input logic [7:0] code, input logic doSync, input logic [31:0] e);
    wr(IDX_DIV1_PHASE_BYPASS, code);
    if (doSync) wr(IDX_SYNC_CONTROL, 8'h01);
    n = 0;
    repeat (40) step();
    while (!risen(0) && n < 200) step();
    gap = n;
    while (!risen(1) && n < 200) step();
    if (n >= 200) giveUp();
    chk("rise gap", e, n - gap);
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    srst = 1'b1;
    apbReq = '0;
    cur = '0;
    prv = '0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < NSLOT; i++) begin
      rdc(SLOT_IDX[i], REG_RESET);
      wr(SLOT_IDX[i], 8'ha5);
      rdc(SLOT_IDX[i], 8'ha5);
    end
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) step();
    chk("reset out", 32'h0000_0000, {26'h000_0000, outClk});
    @(posedge clock);
    srst <= 1'b0;
    rdc(IDX_DIV0_OUT_CONTROL, 8'h00);
    rdc(IDX_DIV3_DUTY_CONTROL, 8'h00);
    foreach (ROWS[i]) begin
      wr(ROWS[i].idx, ROWS[i].wd);
      meas(int'(ROWS[i].pin));
      chk("high", 32'(ROWS[i].hi), hi);
      chk("period", 32'(ROWS[i].per), per);
    end
    wr(IDX_DIV0_OUT_CONTROL, 8'h00);
    wr(IDX_DIV0_CYCLE_COUNTS, 8'h33);
    wr(IDX_DIV1_CYCLE_COUNTS, 8'h33);
    phaseStep(8'h03, 1'b1, 32'h0000_0003);
    phaseStep(8'h02, 1'b0, 32'h0000_0003);
    phaseStep(8'h02, 1'b1, 32'h0000_0002);
    phaseStep(8'h11, 1'b1, 32'h0000_0005);
    apb(1'b1, ad(IDX_DIV0_CYCLE_COUNTS) | 12'h001, 8'h77);
    chk("error", 32'h0000_0001, {31'h0, err});
    rdc(IDX_DIV0_CYCLE_COUNTS, 8'h33);
    apb(1'b0, ad(9'h100), 8'h00);
    chk("error", 32'h0000_0001, {31'h0, err});
    chk("read", 32'h0000_0000, rd);
    wr(IDX_OUTPUT_MODE, 8'h01);
    repeat (3) step();
    repeat (16) begin
      step();
      chk("b off", 32'h0000_0000, {31'h0, outClk[3]});
    end
    wr(IDX_OUTPUT_MODE, 8'h05);
    repeat (3) step();
    repeat (16) begin
      step();
      chk("b copy", {31'h0, outClk[2]}, {31'h0, outClk[3]});
    end
    tally_and_finish();
  end
endmodule
